// ---- design/evlink_pkg.sv ----
// constants shared by the event link router: register map, field layout,
// source codes and destination indices.
// assumes one 100 MHz peripheral clock and a synchronous active-high reset.
package evlink_pkg;

   // ********************************************************
   // register map (byte addresses on the 8-bit register port)
   // ********************************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DST_NUM = 64;
   // setting register n sits at address n
   localparam logic [63:0] DST_EXIST = 64'h01FF_0000_1FFD_D580;
   localparam logic [7:0] ADDR_OPT_C = 8'h40;
   localparam logic [7:0] ADDR_CTRL = 8'h41;
   localparam logic [7:0] ADDR_GRP_MASK0 = 8'h44;
   localparam logic [7:0] ADDR_GRP_CTL0 = 8'h46;
   localparam logic [7:0] ADDR_GRP_BUF0 = 8'h48;
   localparam logic [7:0] ADDR_SINGLE0 = 8'h4C;

   // ********************************************************
   // reset values
   // ********************************************************
   localparam logic [7:0] SEL_RST = 8'h00;
   localparam logic [1:0] LPT_OP_RST = 2'h0;
   localparam logic STOP_RST = 1'b0;
   localparam logic [7:0] GRP_RST = 8'h00;
   localparam logic [7:0] SINGLE_RST = 8'h00;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int unsigned CTRL_STOP_BIT = 0;
   localparam int unsigned CTRL_SWEV_BIT = 1;
   localparam int unsigned GRP_PORT_BIT = 0;
   localparam int unsigned GRP_EDGE_LSB = 1;
   localparam int unsigned SGL_PIN_LSB = 0;
   localparam int unsigned SGL_PORT_BIT = 3;
   localparam int unsigned SGL_DIR_BIT = 4;
   localparam int unsigned SGL_ACT_LSB = 5;

   // edge modes for inputs, actions for single outputs
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] ACT_LOW = 2'h0;
   localparam logic [1:0] ACT_HIGH = 2'h1;
   localparam logic [1:0] ACT_TOGGLE = 2'h2;

   // ********************************************************
   // destination indices
   // ********************************************************
   localparam int unsigned DST_OUT_GRP0 = 20;
   localparam int unsigned DST_IN_GRP0 = 22;
   localparam int unsigned DST_SINGLE0 = 24;

   // ********************************************************
   // source codes produced inside the router
   // ********************************************************
   localparam logic [7:0] CODE_IN_GRP0 = 8'h63;
   localparam logic [7:0] CODE_SINGLE0 = 8'h65;
   localparam logic [7:0] CODE_SW_EVENT = 8'h69;
   localparam int unsigned NUM_SRC = 116;

   // the 116 codes that may be linked; anything else forwards nothing
   function automatic logic code_legal(input logic [7:0] c);
      logic ok;
      ok = 1'b0;
      if (c == 8'h1F || c == 8'h2E) begin
         ok = 1'b1;
      end
      if ((c >= 8'h22 && c <= 8'h24) || (c >= 8'h28 && c <= 8'h2A)) begin
         ok = 1'b1;
      end
      if ((c >= 8'h31 && c <= 8'h35) || (c >= 8'h3A && c <= 8'h3D)) begin
         ok = 1'b1;
      end
      if ((c >= 8'h4E && c <= 8'h56) || (c >= 8'h58 && c <= 8'h6A)) begin
         ok = 1'b1;
      end
      if (c >= 8'h80 && c <= 8'hC6) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   function automatic logic [7:0] edge_hit(input logic [7:0] cur,
                                           input logic [7:0] prev,
                                           input logic [1:0] mode);
      logic [7:0] r;
      r = 8'h00;
      case (mode)
         EDGE_RISE: r = cur & ~prev;
         EDGE_FALL: r = ~cur & prev;
         EDGE_BOTH: r = cur ^ prev;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

endpackage

// ---- design/event_link_router.sv ----
// event link router: forwards one-cycle event pulses from numbered sources
// to destination peripherals, with port linkage and a module stop state.
// assumes all sources, port pins and the register port are synchronous
// to I_CLK_SYS; sources present one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module event_link_router (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [evlink_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [evlink_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [evlink_pkg::DATA_W-1:0] O_RDATA,
   input wire logic [255:0] I_SRC_EVENT,
   output logic [evlink_pkg::DST_NUM-1:0] O_DST_EVENT,
   output logic [1:0] O_LPT_OP_SEL,
   output logic O_MODULE_STOP,
   input wire logic [7:0] I_PORT_B,
   input wire logic [7:0] I_PORT_E,
   output logic [7:0] O_PORT_B,
   output logic [7:0] O_PORT_E,
   output logic [7:0] O_PORT_B_OE_N,
   output logic [7:0] O_PORT_E_OE_N
);
   import evlink_pkg::*;

   // ********************************************************
   // state
   // ********************************************************
   logic [7:0] sel_q [0:DST_NUM-1];
   logic ev_q [0:DST_NUM-1];
   logic [255:0] src_all;
   logic [1:0] lpt_op_q;
   logic stop_q;
   logic sw_ev_q;
   logic [7:0] grp_mask_q [0:1];
   logic [7:0] grp_ctl_q [0:1];
   logic [7:0] grp_buf_q [0:1];
   logic grp_edge_q [0:1];
   logic [7:0] single_q [0:3];
   logic single_edge_q [0:3];
   logic [7:0] pin_in [0:1];
   logic [7:0] pin_prev_q [0:1];
   logic [7:0] pin_q [0:1];
   logic [7:0] pin_d [0:1];
   logic [7:0] drive_q [0:1];
   logic [7:0] drive_d [0:1];
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;

   assign pin_in[0] = I_PORT_B;
   assign pin_in[1] = I_PORT_E;

   // ********************************************************
   // source vector: external pulses plus the router's own events
   // ********************************************************
   // internal source codes
   always_comb begin
      src_all = I_SRC_EVENT;
      src_all[CODE_IN_GRP0] = grp_edge_q[0];
      src_all[CODE_IN_GRP0 + 8'h01] = grp_edge_q[1];
      src_all[CODE_SINGLE0] = single_edge_q[0];
      src_all[CODE_SINGLE0 + 8'h01] = single_edge_q[1];
      src_all[CODE_SINGLE0 + 8'h02] = single_edge_q[2];
      src_all[CODE_SINGLE0 + 8'h03] = single_edge_q[3];
      src_all[CODE_SW_EVENT] = sw_ev_q;
   end

   // ********************************************************
   // setting registers and forwarding, one per destination index set in DST_EXIST; other indices read 0 and never pulse
   // ********************************************************
   genvar i;
   generate
      for (i = 0; i < DST_NUM; i++) begin : g_dst
         if (DST_EXIST[i]) begin : g_on
            always_ff @(posedge I_CLK_SYS) begin
               if (I_RST) begin
                  sel_q[i] <= SEL_RST;
               end else if (I_WR && I_ADDR == 8'(i)) begin
                  sel_q[i] <= I_WDATA;
               end
            end
            // select, gate, register
            // illegal codes forward nothing rather than a stray source
            always_ff @(posedge I_CLK_SYS) begin
               if (I_RST) begin
                  ev_q[i] <= 1'b0;
               end else begin
                  ev_q[i] <= !stop_q && sel_q[i] != 8'h00 && code_legal(sel_q[i])
                             && src_all[sel_q[i]];
               end
            end
         end else begin : g_off
            assign sel_q[i] = 8'h00;
            assign ev_q[i] = 1'b0;
         end
         assign O_DST_EVENT[i] = ev_q[i];
      end
   endgenerate

   // ********************************************************
   // option and control registers
   // ********************************************************
   // low-power timer reaction
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         lpt_op_q <= LPT_OP_RST;
      end else if (I_WR && I_ADDR == ADDR_OPT_C) begin
         lpt_op_q <= I_WDATA[1:0];
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         stop_q <= STOP_RST;
      end else if (I_WR && I_ADDR == ADDR_CTRL) begin
         stop_q <= I_WDATA[CTRL_STOP_BIT];
      end
   end

   // software event: write-one pulse, never stored
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         sw_ev_q <= 1'b0;
      end else begin
         sw_ev_q <= I_WR && I_ADDR == ADDR_CTRL && I_WDATA[CTRL_SWEV_BIT] && !stop_q;
      end
   end

   assign O_LPT_OP_SEL = lpt_op_q;
   assign O_MODULE_STOP = stop_q;

   // ********************************************************
   // port sampling
   // ********************************************************
   // edge history is frozen while stopped, so no stale edge on wake-up
   // would be invented beyond the real change
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         pin_prev_q[0] <= 8'h00;
         pin_prev_q[1] <= 8'h00;
      end else if (!stop_q) begin
         pin_prev_q[0] <= pin_in[0];
         pin_prev_q[1] <= pin_in[1];
      end
   end

   // ********************************************************
   // port groups
   // ********************************************************
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_grp
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               grp_mask_q[g] <= GRP_RST;
               grp_ctl_q[g] <= GRP_RST;
            end else if (I_WR && I_ADDR == ADDR_GRP_MASK0 + 8'(g)) begin
               grp_mask_q[g] <= I_WDATA;
            end else if (I_WR && I_ADDR == ADDR_GRP_CTL0 + 8'(g)) begin
               grp_ctl_q[g] <= I_WDATA;
            end
         end

         // capture masked pins; capture wins over a software write
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               grp_buf_q[g] <= GRP_RST;
            end else if (ev_q[DST_IN_GRP0 + g]) begin
               grp_buf_q[g] <= pin_in[grp_ctl_q[g][GRP_PORT_BIT]] & grp_mask_q[g];
            end else if (I_WR && I_ADDR == ADDR_GRP_BUF0 + 8'(g)) begin
               grp_buf_q[g] <= I_WDATA;
            end
         end

         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               grp_edge_q[g] <= 1'b0;
            end else begin
               grp_edge_q[g] <= !stop_q && |(grp_mask_q[g] &
                  edge_hit(pin_in[grp_ctl_q[g][GRP_PORT_BIT]],
                           pin_prev_q[grp_ctl_q[g][GRP_PORT_BIT]],
                           grp_ctl_q[g][GRP_EDGE_LSB +: 2]));
            end
         end
      end
   endgenerate

   // ********************************************************
   // single ports
   // ********************************************************
   genvar k;
   generate
      for (k = 0; k < 4; k++) begin : g_sgl
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               single_q[k] <= SINGLE_RST;
            end else if (I_WR && I_ADDR == ADDR_SINGLE0 + 8'(k)) begin
               single_q[k] <= I_WDATA;
            end
         end

         // input edge on the chosen pin
         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               single_edge_q[k] <= 1'b0;
            end else begin
               // a function result cannot be bit-selected, so mask the chosen pin
               single_edge_q[k] <= !stop_q && !single_q[k][SGL_DIR_BIT] &&
                  |(edge_hit(pin_in[single_q[k][SGL_PORT_BIT]],
                             pin_prev_q[single_q[k][SGL_PORT_BIT]],
                             single_q[k][SGL_ACT_LSB +: 2]) &
                    (8'h01 << single_q[k][SGL_PIN_LSB +: 3]));
            end
         end
      end
   endgenerate

   // ********************************************************
   // port outputs driven by output groups and single outputs
   // ********************************************************
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         always_comb begin
            pin_d[p] = pin_q[p];
            drive_d[p] = 8'h00;
            for (int gg = 0; gg < 2; gg++) begin
               if (grp_ctl_q[gg][GRP_PORT_BIT] == 1'(p)) begin
                  if (sel_q[DST_OUT_GRP0 + gg] != 8'h00) begin
                     drive_d[p] = drive_d[p] | grp_mask_q[gg];
                  end
                  if (ev_q[DST_OUT_GRP0 + gg]) begin
                     pin_d[p] = (pin_d[p] & ~grp_mask_q[gg]) |
                                (grp_buf_q[gg] & grp_mask_q[gg]);
                  end
               end
            end
            for (int kk = 0; kk < 4; kk++) begin
               if (single_q[kk][SGL_PORT_BIT] == 1'(p) && single_q[kk][SGL_DIR_BIT]) begin
                  if (sel_q[DST_SINGLE0 + kk] != 8'h00) begin
                     drive_d[p][single_q[kk][SGL_PIN_LSB +: 3]] = 1'b1;
                  end
                  if (ev_q[DST_SINGLE0 + kk]) begin
                     case (single_q[kk][SGL_ACT_LSB +: 2])
                        ACT_LOW: pin_d[p][single_q[kk][SGL_PIN_LSB +: 3]] = 1'b0;
                        ACT_HIGH: pin_d[p][single_q[kk][SGL_PIN_LSB +: 3]] = 1'b1;
                        ACT_TOGGLE: pin_d[p][single_q[kk][SGL_PIN_LSB +: 3]] =
                           ~pin_q[p][single_q[kk][SGL_PIN_LSB +: 3]];
                        default: ;
                     endcase
                  end
               end
            end
         end

         always_ff @(posedge I_CLK_SYS) begin
            if (I_RST) begin
               pin_q[p] <= 8'h00;
               drive_q[p] <= 8'h00;
            end else begin
               pin_q[p] <= pin_d[p];
               drive_q[p] <= drive_d[p];
            end
         end
      end
   endgenerate

   assign O_PORT_B = pin_q[0];
   assign O_PORT_E = pin_q[1];
   assign O_PORT_B_OE_N = ~drive_q[0];
   assign O_PORT_E_OE_N = ~drive_q[1];

   // ********************************************************
   // register read
   // ********************************************************
   always_comb begin
      rd_mux = 8'h00;
      if (I_ADDR < 8'(DST_NUM)) begin
         rd_mux = sel_q[I_ADDR[5:0]];
      end else begin
         case (I_ADDR)
            ADDR_OPT_C: rd_mux = {6'h00, lpt_op_q};
            ADDR_CTRL: rd_mux = {7'h00, stop_q};
            ADDR_GRP_MASK0: rd_mux = grp_mask_q[0];
            ADDR_GRP_MASK0 + 8'h01: rd_mux = grp_mask_q[1];
            ADDR_GRP_CTL0: rd_mux = grp_ctl_q[0];
            ADDR_GRP_CTL0 + 8'h01: rd_mux = grp_ctl_q[1];
            ADDR_GRP_BUF0: rd_mux = grp_buf_q[0];
            ADDR_GRP_BUF0 + 8'h01: rd_mux = grp_buf_q[1];
            ADDR_SINGLE0: rd_mux = single_q[0];
            ADDR_SINGLE0 + 8'h01: rd_mux = single_q[1];
            ADDR_SINGLE0 + 8'h02: rd_mux = single_q[2];
            ADDR_SINGLE0 + 8'h03: rd_mux = single_q[3];
            default: rd_mux = 8'h00;
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= I_RD ? rd_mux : 8'h00;
      end
   end

   assign O_RDATA = rdata_q;

endmodule

`default_nettype wire

// ---- dv/evlink_chk.sv ----
// checker for the event link router, watching its top-level ports only.
// assumes one clock, synchronous active-high reset, registers at their
// package addresses, and source pulses presented by the far-side model.
`timescale 1ns/1ns
`default_nettype none
module evlink_chk
   import evlink_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   input wire logic [evlink_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [evlink_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [evlink_pkg::DATA_W-1:0] O_RDATA,
   input wire logic [255:0] I_SRC_EVENT,
   input wire logic [evlink_pkg::DST_NUM-1:0] O_DST_EVENT,
   input wire logic [1:0] O_LPT_OP_SEL,
   input wire logic O_MODULE_STOP
);
   // ********************************************************
   // shadow of destination 7 select
   // ********************************************************
   logic [7:0] sel7_q;
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         sel7_q <= 8'h00;
      end else if (I_WR && I_ADDR == 8'h07) begin
         sel7_q <= I_WDATA;
      end
   end

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   // ********************************************************
   // assertions
   // ********************************************************
   rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data not zero outside a read answer");
   absent_dst_a: assert property ((O_DST_EVENT & ~DST_EXIST) == 64'h0)
      else $error("pulse on a destination that has no register");
   sel_read_a: assert property ($past(I_RD && I_ADDR == 8'h07) |-> O_RDATA == $past(sel7_q))
      else $error("select readback differs from last write");
   fwd_dst_a: assert property ($past(sel7_q == 8'h1F && I_SRC_EVENT[8'h1F] && !O_MODULE_STOP)
      |-> O_DST_EVENT[7])
      else $error("selected source not forwarded one cycle later");
   dst_cause_a: assert property (O_DST_EVENT[7] |-> $past(sel7_q != 8'h00 &&
      (I_SRC_EVENT[sel7_q] || (sel7_q >= 8'h63 && sel7_q <= 8'h69))))
      else $error("destination pulse without its selected source");
   stop_quiet_a: assert property ($past(O_MODULE_STOP) |-> O_DST_EVENT == 64'h0)
      else $error("forwarding while stopped");
   stop_write_a: assert property (I_WR && I_ADDR == ADDR_CTRL
      |=> O_MODULE_STOP == $past(I_WDATA[CTRL_STOP_BIT]))
      else $error("stop state does not follow control write");
   lpt_write_a: assert property (I_WR && I_ADDR == ADDR_OPT_C
      |=> O_LPT_OP_SEL == $past(I_WDATA[1:0]))
      else $error("timer reaction select does not follow write");
   lpt_hold_a: assert property (!(I_WR && I_ADDR == ADDR_OPT_C) |=> $stable(O_LPT_OP_SEL))
      else $error("timer reaction select changed without a write");

   cover property (O_DST_EVENT[7]);
   cover property (O_MODULE_STOP && I_SRC_EVENT[8'h1F]);
   cover property (I_WR && I_ADDR == ADDR_OPT_C ##1 O_LPT_OP_SEL == 2'h3);
endmodule
`default_nettype wire

// ---- dv/periph_far_model.sv ----
// far-side peripherals: event sources and the pins of ports B and E.
// assumes requests from the bench are synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none
module periph_far_model (
   input wire logic i_clk,
   input wire logic i_fire,
   input wire logic [7:0] i_code,
   input wire logic [7:0] i_drive_b,
   input wire logic [7:0] i_drive_e,
   input wire logic [7:0] i_out_b,
   input wire logic [7:0] i_oen_b,
   input wire logic [7:0] i_out_e,
   input wire logic [7:0] i_oen_e,
   output var logic [255:0] o_src,
   output logic [7:0] o_pin_b,
   output logic [7:0] o_pin_e
);
   // ********************************************************
   // sources: one-cycle pulse a clock after the request
   // ********************************************************
   initial o_src = 256'h0;
   always @(posedge i_clk) begin
      o_src <= i_fire ? (256'h1 << i_code) : 256'h0;
   end

   // ********************************************************
   // pins: router wins where its drive enable is low
   // ********************************************************
   assign o_pin_b = (i_out_b & ~i_oen_b) | (i_drive_b & i_oen_b);
   assign o_pin_e = (i_out_e & ~i_oen_e) | (i_drive_e & i_oen_e);
endmodule
`default_nettype wire

// ---- dv/event_link_router_bench.sv ----
// self-checking bench for the event link router.
// assumes the package address map and the far-side peripheral model.
`timescale 1ns/1ns
`default_nettype none
module event_link_router_bench;
   import evlink_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic fire = 1'b0;
   logic [7:0] code = 8'h00;
   logic [7:0] drv_b = 8'h00;
   logic [7:0] rdata, pin_b, pin_e, pout_b, pout_e, oen_b, oen_e, rv;
   logic [255:0] src;
   logic [63:0] dst, seen;
   logic [1:0] low_power_timer;
   logic stop;
   int n_fail = 0;
   int tests_run = 0;
   int hits;
   logic [7:0] codes [28] = '{8'h1F, 8'h22, 8'h24, 8'h28, 8'h2A, 8'h2E, 8'h31, 8'h35,
      8'h3A, 8'h3D, 8'h4E, 8'h51, 8'h52, 8'h56, 8'h58, 8'h62, 8'h6A, 8'h80, 8'h89,
      8'h8A, 8'h94, 8'h9D, 8'h9E, 8'hA5, 8'hA6, 8'hAD, 8'hC5, 8'hC6};

   always #5 clk = ~clk;

   event_link_router u_event_link_router (.I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SRC_EVENT(src),
      .O_DST_EVENT(dst), .O_LPT_OP_SEL(low_power_timer), .O_MODULE_STOP(stop), .I_PORT_B(pin_b),
      .I_PORT_E(pin_e), .O_PORT_B(pout_b), .O_PORT_E(pout_e), .O_PORT_B_OE_N(oen_b),
      .O_PORT_E_OE_N(oen_e));
   periph_far_model u_periph_far_model (.i_clk(clk), .i_fire(fire), .i_code(code),
      .i_drive_b(drv_b), .i_drive_e(8'h00), .i_out_b(pout_b), .i_oen_b(oen_b),
      .i_out_e(pout_e), .i_oen_e(oen_e), .o_src(src), .o_pin_b(pin_b), .o_pin_e(pin_e));

   // ********************************************************
   // compare, access and closing tasks
   // ********************************************************
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp64(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // four cycles cover both the direct and the internal-source latency
   task automatic watch();
      seen = 64'h0;
      hits = 0;
      repeat (4) begin
         #1;
         seen |= dst;
         hits += $countones(dst);
         @(posedge clk);
      end
   endtask
   task automatic fire_src(input logic [7:0] c);
      @(posedge clk);
      fire <= 1'b1;
      code <= c;
      @(posedge clk);
      fire <= 1'b0;
      watch();
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end

   // ********************************************************
   // scenarios
   // ********************************************************
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      reg_rd(8'h07, rv);
      cmp8("select reset", SEL_RST, rv);
      cmp8("drive enable reset", 8'hFF, oen_b);
      for (int n = 0; n < 64; n++) reg_wr(n[7:0], 8'h80);
      for (int n = 0; n < 64; n++) begin
         reg_rd(n[7:0], rv);
         cmp8("select readback", DST_EXIST[n] ? 8'h80 : 8'h00, rv);
      end
      fire_src(8'h80);
      cmp64("fanout", DST_EXIST, seen);
      cmp8("fanout pulses", 8'($countones(DST_EXIST)), 8'(hits));
      for (int n = 0; n < 64; n++) reg_wr(n[7:0], 8'h00);
      fire_src(8'h80);
      cmp64("all disabled", 64'h0, seen);
      // illegal code is stored but must forward nothing
      reg_wr(8'h07, 8'h25);
      reg_rd(8'h07, rv);
      cmp8("illegal stored", 8'h25, rv);
      fire_src(8'h25);
      cmp64("illegal code", 64'h0, seen);
      foreach (codes[i]) begin
         reg_wr(8'h07, codes[i]);
         fire_src(codes[i]);
         cmp64("code route", 64'h80, seen);
      end
      reg_wr(8'h07, 8'h1F);
      reg_wr(ADDR_CTRL, 8'h01);
      fire_src(8'h1F);
      cmp64("stopped", 64'h0, seen);
      cmp8("stop flag", 8'h01, {7'h00, stop});
      reg_wr(ADDR_CTRL, 8'h00);
      fire_src(8'h1F);
      cmp64("running again", 64'h80, seen);
      for (int k = 0; k < 4; k++) begin
         reg_wr(ADDR_OPT_C, k[7:0]);
         reg_rd(ADDR_OPT_C, rv);
         cmp8("timer reaction", k[7:0], {6'h00, low_power_timer});
      end
      reg_wr(8'd18, CODE_SW_EVENT);
      reg_wr(ADDR_CTRL, 8'h02);
      watch();
      cmp64("software event", 64'h1 << 18, seen);
      reg_wr(ADDR_GRP_MASK0, 8'h0F);
      reg_wr(ADDR_GRP_CTL0, 8'h00);
      reg_wr(8'd18, CODE_IN_GRP0);
      @(posedge clk);
      drv_b <= 8'h5A;
      watch();
      cmp64("group edge", 64'h1 << 18, seen);
      reg_wr(8'd22, 8'h80);
      fire_src(8'h80);
      reg_rd(ADDR_GRP_BUF0, rv);
      cmp8("group capture", 8'h0A, rv);
      reg_wr(8'd20, 8'h81);
      fire_src(8'h81);
      cmp8("group output", 8'h0A, pout_b & 8'h0F);
      cmp8("group drive", 8'hF0, oen_b);
      reg_wr(ADDR_SINGLE0, 8'h3B);
      reg_wr(8'd24, 8'h82);
      fire_src(8'h82);
      cmp8("single high", 8'h08, pout_e & 8'h08);
      cmp8("single drive", 8'hF7, oen_e);
      reg_wr(ADDR_SINGLE0, 8'h5B);
      fire_src(8'h82);
      cmp8("single toggle", 8'h00, pout_e & 8'h08);
      reg_rd(8'hF0, rv);
      cmp8("unmapped read", 8'h00, rv);
      tally_and_finish();
   end
endmodule

bind event_link_router evlink_chk u_evlink_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .I_SRC_EVENT(I_SRC_EVENT), .O_DST_EVENT(O_DST_EVENT), .O_LPT_OP_SEL(O_LPT_OP_SEL),
   .O_MODULE_STOP(O_MODULE_STOP));
`default_nettype wire
